/* File: core/ias_pkg.sv */
package ias_pkg;
	// data and address widths of the 8-bit core
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	// number of maskable request latches
	localparam int MASKABLE_COUNT = 22;
	// slot codes index the vector table; maskable source i uses slot SLOT_FIRST_MASKABLE + i
	localparam int SLOT_W = 5;
	localparam logic [SLOT_W-1:0] SLOT_TRAP = 5'h00;
	localparam logic [SLOT_W-1:0] SLOT_UNDEF = 5'h01;
	localparam logic [SLOT_W-1:0] SLOT_FIRST_MASKABLE = 5'h02;
	// vector table: slot 0 at the top, each slot two bytes, high byte first
	localparam logic [ADDR_W-1:0] VEC_TABLE_TOP = 16'hfffe;
	// stack pointer after reset
	localparam logic [ADDR_W-1:0] SP_RESET = 16'h00ff;
	// opcode that reads back from unmapped space and decodes as the trap
	localparam logic [DATA_W-1:0] TRAP_OPCODE = 8'hff;
	// program status byte layout
	localparam int PSW_IMF_BIT = 7;
	localparam int PSW_BANK_BIT = 6;
	localparam int FLAGS_W = 6;
	// bytes moved per entry or exit
	localparam logic [ADDR_W-1:0] STACK_FRAME = 16'h0003;
	// acceptance length in machine cycles, counted from the start cycle
	localparam int ACCEPT_CYCLES = 8;
	localparam logic [2:0] ACC_LAST_STEP = 3'(ACCEPT_CYCLES - 2);
	// bank geometry
	localparam int GPR_PER_BANK = 8;
	localparam int INDEX_W = 16;
	localparam logic [INDEX_W-1:0] REG_RESET = 16'h0000;
	typedef enum logic [1:0] {IAS_IDLE, IAS_ACCEPT, IAS_RETURN} ias_state_t;
endpackage

/* File: core/ias_reg_bank.sv */
`timescale 1ns/100ps
// two banks of eight byte registers and two index registers
module ias_reg_bank (
	input wire logic clk, // machine-cycle clock
	input wire logic rst_b, // async reset, active low
	input wire logic bank_select_field, // 0 bank_zero, 1 bank_one
	input wire logic gpr_wr, // byte register write strobe
	input wire logic [2:0] gpr_sel, // byte register number
	input wire logic [7:0] gpr_wdata, // byte register write data
	output logic [7:0] gpr_rdata, // byte register read data
	input wire logic idx_wr, // index register write strobe
	input wire logic idx_sel, // 0 index_reg_x, 1 index_reg_y
	input wire logic [15:0] idx_wdata, // index register write data
	output logic [15:0] idx_rdata // index register read data
);
	import ias_pkg::*;
	logic [7:0] gpr_d [2][GPR_PER_BANK];
	logic [7:0] gpr_q [2][GPR_PER_BANK];
	logic [INDEX_W-1:0] idx_d [2][2];
	logic [INDEX_W-1:0] idx_q [2][2];

	// only the selected bank is written; the other keeps its contents
	always_comb
	begin
		gpr_d = gpr_q;
		idx_d = idx_q;
		if (gpr_wr)
			gpr_d[bank_select_field][gpr_sel] = gpr_wdata; // RL12
		if (idx_wr)
			idx_d[bank_select_field][idx_sel] = idx_wdata; // RL12
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int b = 0; b < 2; b++)
			begin
				for (int r = 0; r < GPR_PER_BANK; r++)
					gpr_q[b][r] <= REG_RESET[7:0];
				idx_q[b][0] <= REG_RESET;
				idx_q[b][1] <= REG_RESET;
			end
		end
		else
		begin
			gpr_q <= gpr_d;
			idx_q <= idx_d;
		end
	end

	assign gpr_rdata = gpr_q[bank_select_field][gpr_sel];
	assign idx_rdata = idx_q[bank_select_field][idx_sel];
endmodule // ias_reg_bank

/* File: core/ias_req_latch.sv */
`timescale 1ns/100ps
// request latches: set by a source pulse, cleared by acceptance or an instruction
module ias_req_latch #(
	parameter int N = ias_pkg::MASKABLE_COUNT
) (
	input wire logic clk, // machine-cycle clock
	input wire logic rst_b, // async reset, active low
	input wire logic [N-1:0] src_set, // request pulses from sources
	input wire logic [N-1:0] sw_clr, // clear pulses from an instruction
	input wire logic [N-1:0] acc_clr, // clear pulse for the accepted source
	output logic [N-1:0] irq_request_latch // held requests
);
	import ias_pkg::*;
	logic [N-1:0] lat_d;
	logic [N-1:0] lat_q;

	// a new request wins over a clear in the same cycle so no event is lost
	always_comb
	begin
		lat_d = lat_q;
		for (int i = 0; i < N; i++)
		begin
			if (src_set[i])
				lat_d[i] = 1'b1;
			else if (sw_clr[i] || acc_clr[i])
				lat_d[i] = 1'b0; // RL2 RL18
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			lat_q <= '0; // RL18
		else
			lat_q <= lat_d;
	end

	assign irq_request_latch = lat_q;
endmodule // ias_req_latch

/* File: core/ias_sequencer.sv */
`timescale 1ns/100ps
// Overview of operation
// RL1: acceptance clears the master enable first, blocking further maskable requests.
// RL2: acceptance clears only the accepted source's request latch.
// RL3: push status, pc high, pc low; stack pointer drops by three.
// RL4: after stacking, load the pc from the accepted source's vector slot.
// RL5: execution resumes at the service entry once the vector is loaded.
// RL6: stacked status byte holds bank selection and master enable.
// RL7: maskable requests wait while master enable is zero.
// RL8: with master enable set, nest only sources whose enable flag is set.
// RL9: software clears the serviced enable before re-enabling; keep trap handlers short.
// RL10: hardware stacks only pc and status, never the general registers.
// RL11: maskable return restores bank selection from the popped status byte.
// RL12: two banks, each eight byte registers and two 16-bit index registers.
// RL13: the trap instruction starts top-priority acceptance at once.
// RL14: fetch from unmapped address yields 0xff, which raises the trap.
// RL15: undefined opcode raises its own interrupt, vectored like the trap.
// RL16: undefined-opcode interrupt aborts any non-maskable processing and restarts acceptance.
// RL17: acceptance takes eight machine cycles after the current instruction completes.
// RL18: a request latch holds until accepted, reset, or cleared by instruction.
// RL19: maskable routines end with one return, non-maskable with the other.
// RL20: returns pop pc low, pc high, status; stack pointer rises by three.
module ias_sequencer #(
	parameter int N_SRC = ias_pkg::MASKABLE_COUNT,
	parameter logic [ias_pkg::ADDR_W-1:0] VEC_TOP = ias_pkg::VEC_TABLE_TOP
) (
	input wire logic clk, // machine-cycle clock, 40 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic [N_SRC-1:0] src_irq_set, // peripheral request pulses
	input wire logic [N_SRC-1:0] src_latch_clr, // instruction clears of latches
	input wire logic [N_SRC-1:0] source_enable_flags, // individual enables
	output logic [N_SRC-1:0] irq_request_latch, // held requests
	input wire logic instr_done, // current instruction completes this cycle
	input wire logic fetch_req, // opcode fetch strobe
	input wire logic fetch_addr_ok, // fetch address is mapped
	input wire logic [ias_pkg::DATA_W-1:0] fetch_mem_data, // memory data for the fetch
	output logic [ias_pkg::DATA_W-1:0] opcode_q, // fetched opcode to decoder
	input wire logic undef_opcode, // decoder found an undefined opcode
	input wire logic imf_set, // enable instruction
	input wire logic imf_clr, // disable instruction
	input wire logic bank_wr, // bank manipulation instruction
	input wire logic bank_wdata, // bank to select
	input wire logic sp_wr, // stack pointer load
	input wire logic [ias_pkg::ADDR_W-1:0] sp_wdata, // stack pointer value
	input wire logic ret_maskable, // return_from_maskable executes
	input wire logic ret_nonmaskable, // return_from_nonmaskable executes
	input wire logic [ias_pkg::ADDR_W-1:0] pc_cur, // address to resume after the instruction
	input wire logic [ias_pkg::FLAGS_W-1:0] cpu_flags, // alu flags for the status byte
	output logic [ias_pkg::FLAGS_W-1:0] flags_restore_q, // flags popped on return
	output logic flags_restore_load_q, // pulse: take flags_restore_q
	output logic master_irq_enable_q, // master enable flag
	output logic bank_select_q, // current bank
	output logic [ias_pkg::ADDR_W-1:0] sp_q, // stack pointer
	output logic mem_rd_q, // stack/vector read strobe
	output logic mem_wr_q, // stack write strobe
	output logic [ias_pkg::ADDR_W-1:0] mem_addr_q, // memory address
	output logic [ias_pkg::DATA_W-1:0] mem_wdata_q, // memory write data
	input wire logic [ias_pkg::DATA_W-1:0] mem_rdata, // read data, a cycle after strobe
	output logic pc_load_q, // pulse: take pc_new_q
	output logic [ias_pkg::ADDR_W-1:0] pc_new_q, // vector or return address
	output logic cpu_hold, // pipeline stalls while a sequence runs
	output logic nmi_active_q, // non-maskable service in progress
	input wire logic gpr_wr, // byte register write strobe
	input wire logic [2:0] gpr_sel, // byte register number
	input wire logic [7:0] gpr_wdata, // byte register write data
	output logic [7:0] gpr_rdata, // byte register read data
	input wire logic idx_wr, // index register write strobe
	input wire logic idx_sel, // index register select
	input wire logic [15:0] idx_wdata, // index register write data
	output logic [15:0] idx_rdata // index register read data
);
	import ias_pkg::*;

	ias_state_t state_d, state_q;
	logic [2:0] step_d, step_q;
	logic [SLOT_W-1:0] slot_d, slot_q;
	logic [ADDR_W-1:0] sp_d, sp_base_d, sp_base_q;
	logic [ADDR_W-1:0] pc_keep_d, pc_keep_q;
	logic [DATA_W-1:0] psw_keep_d, psw_keep_q;
	logic [DATA_W-1:0] byte_keep_d, byte_keep_q;
	logic imf_d, bank_d, nmi_d;
	logic trap_pend_d, trap_pend_q, undef_pend_d, undef_pend_q;
	logic mem_rd_d, mem_wr_d, pc_load_d, flags_load_d;
	logic [ADDR_W-1:0] mem_addr_d, pc_new_d;
	logic [DATA_W-1:0] mem_wdata_d, opcode_d;
	logic [FLAGS_W-1:0] flags_d;
	logic [N_SRC-1:0] acc_clr_d, acc_clr_q;
	logic [N_SRC-1:0] eligible;
	logic mask_any;
	logic [SLOT_W-1:0] mask_slot;
	logic [N_SRC-1:0] mask_onehot;
	logic [DATA_W-1:0] fetched;
	logic start_any, undef_abort;
	logic [SLOT_W-1:0] start_slot;
	logic [ADDR_W-1:0] start_sp;

	ias_req_latch #(.N(N_SRC)) u_latch (
		.clk(clk),
		.rst_b(rst_b),
		.src_set(src_irq_set),
		.sw_clr(src_latch_clr),
		.acc_clr(acc_clr_q),
		.irq_request_latch(irq_request_latch)
	);

	// general registers live in banks; acceptance never stacks them
	ias_reg_bank u_bank (
		.clk(clk),
		.rst_b(rst_b),
		.bank_select_field(bank_select_q), // RL10 RL12
		.gpr_wr(gpr_wr),
		.gpr_sel(gpr_sel),
		.gpr_wdata(gpr_wdata),
		.gpr_rdata(gpr_rdata),
		.idx_wr(idx_wr),
		.idx_sel(idx_sel),
		.idx_wdata(idx_wdata),
		.idx_rdata(idx_rdata)
	);

	// fixed order among maskable sources; level arbitration sits outside this block
	always_comb
	begin
		eligible = irq_request_latch & source_enable_flags; // RL8
		mask_any = 1'b0;
		mask_slot = SLOT_FIRST_MASKABLE;
		mask_onehot = '0;
		for (int i = N_SRC - 1; i >= 0; i--)
		begin
			if (eligible[i])
			begin
				mask_any = 1'b1;
				mask_slot = SLOT_FIRST_MASKABLE + SLOT_W'(i);
				mask_onehot = '0;
				mask_onehot[i] = 1'b1;
			end
		end
	end

	// unmapped fetches read as the trap opcode
	assign fetched = fetch_addr_ok ? fetch_mem_data : TRAP_OPCODE; // RL14
	assign opcode_d = fetch_req ? fetched : opcode_q;

	// undefined opcode preempts anything except its own acceptance
	assign undef_abort = undef_pend_q &&
		!(state_q == IAS_ACCEPT && slot_q == SLOT_UNDEF); // RL16

	// undefined requests start at once, trap requests once the sequencer is idle; maskable ones also wait for the instruction end
	always_comb
	begin
		start_any = 1'b0;
		start_slot = mask_slot;
		if (undef_abort)
		begin
			start_any = 1'b1;
			start_slot = SLOT_UNDEF; // RL15 RL16
		end
		else if (state_q == IAS_IDLE && trap_pend_q)
		begin
			start_any = 1'b1;
			start_slot = SLOT_TRAP; // RL13
		end
		else if (state_q == IAS_IDLE && instr_done && master_irq_enable_q && mask_any)
		begin
			start_any = 1'b1; // RL7 RL8 RL17
		end
	end

	// a restart must reuse the original stack base, not a half-decremented pointer
	assign start_sp = (state_q == IAS_ACCEPT) ? sp_base_q : sp_q;

	// sequencer next state
	always_comb
	begin
		state_d = state_q;
		step_d = step_q;
		slot_d = slot_q;
		sp_d = sp_q;
		sp_base_d = sp_base_q;
		pc_keep_d = pc_keep_q;
		psw_keep_d = psw_keep_q;
		byte_keep_d = byte_keep_q;
		imf_d = master_irq_enable_q;
		bank_d = bank_select_q;
		nmi_d = nmi_active_q;
		mem_rd_d = 1'b0;
		mem_wr_d = 1'b0;
		mem_addr_d = mem_addr_q;
		mem_wdata_d = mem_wdata_q;
		pc_load_d = 1'b0;
		pc_new_d = pc_new_q;
		flags_d = flags_restore_q;
		flags_load_d = 1'b0;
		acc_clr_d = '0;
		// a fetched trap opcode or an undefined one stays pending until taken
		trap_pend_d = trap_pend_q || (fetch_req && fetched == TRAP_OPCODE); // RL14
		undef_pend_d = undef_pend_q || undef_opcode;
		// software control only while no sequence owns these fields
		if (state_q == IAS_IDLE)
		begin
			if (imf_set)
				imf_d = 1'b1;
			if (imf_clr)
				imf_d = 1'b0;
			if (bank_wr)
				bank_d = bank_wdata;
			if (sp_wr)
				sp_d = sp_wdata;
		end
		if (start_any)
		begin
			state_d = IAS_ACCEPT;
			step_d = 3'h0;
			slot_d = start_slot;
			imf_d = 1'b0; // RL1
			sp_base_d = start_sp;
			sp_d = start_sp;
			if (state_q != IAS_ACCEPT)
			begin
				pc_keep_d = pc_cur;
				psw_keep_d = {master_irq_enable_q, bank_select_q, cpu_flags}; // RL6
			end
			// a fresh event in the start cycle stays pending so it is not lost
			if (start_slot == SLOT_UNDEF)
				undef_pend_d = undef_opcode;
			else if (start_slot == SLOT_TRAP)
				trap_pend_d = fetch_req && fetched == TRAP_OPCODE; // RL14
			else
				acc_clr_d = mask_onehot; // RL2
			if (start_slot == SLOT_UNDEF || start_slot == SLOT_TRAP)
				nmi_d = 1'b1;
			// first push: status byte with master enable
			mem_wr_d = 1'b1;
			mem_addr_d = start_sp;
			mem_wdata_d = (state_q != IAS_ACCEPT) ?
				{master_irq_enable_q, bank_select_q, cpu_flags} : psw_keep_q; // RL3 RL6
		end
		else if (state_q == IAS_ACCEPT)
		begin
			step_d = step_q + 3'h1;
			unique case (step_q)
				3'h0:
				begin
					mem_wr_d = 1'b1;
					mem_addr_d = sp_base_q - 16'h0001;
					mem_wdata_d = pc_keep_q[15:8]; // RL3
				end
				3'h1:
				begin
					mem_wr_d = 1'b1;
					mem_addr_d = sp_base_q - 16'h0002;
					mem_wdata_d = pc_keep_q[7:0]; // RL3
					sp_d = sp_base_q - STACK_FRAME; // RL3
				end
				3'h2:
				begin
					mem_rd_d = 1'b1;
					mem_addr_d = VEC_TOP - ADDR_W'({slot_q, 1'b0}); // RL4
				end
				3'h3:
				begin
					mem_rd_d = 1'b1;
					mem_addr_d = VEC_TOP - ADDR_W'({slot_q, 1'b0}) + 16'h0001; // RL4
				end
				3'h4:
					byte_keep_d = mem_rdata;
				3'h5:
				begin
					pc_new_d = {byte_keep_q, mem_rdata}; // RL4
					pc_load_d = 1'b1; // RL5
				end
				default:
				begin
					// padding cycle that makes up the fixed acceptance length
					if (step_q == ACC_LAST_STEP)
						state_d = IAS_IDLE; // RL17
				end
			endcase
		end
		else if (state_q == IAS_RETURN)
		begin
			step_d = step_q + 3'h1;
			unique case (step_q)
				3'h0:
				begin
					mem_rd_d = 1'b1;
					mem_addr_d = sp_q + 16'h0002; // RL20
				end
				3'h1:
				begin
					mem_rd_d = 1'b1;
					mem_addr_d = sp_q + STACK_FRAME; // RL20
					byte_keep_d = mem_rdata;
				end
				3'h2:
					pc_new_d = {mem_rdata, byte_keep_q};
				default:
				begin
					// status byte arrives: restore enable, bank and flags
					imf_d = mem_rdata[PSW_IMF_BIT];
					bank_d = mem_rdata[PSW_BANK_BIT]; // RL11
					flags_d = mem_rdata[FLAGS_W-1:0];
					flags_load_d = 1'b1;
					pc_load_d = 1'b1; // RL20
					sp_d = sp_q + STACK_FRAME; // RL20
					state_d = IAS_IDLE;
				end
			endcase
		end
		else if (ret_maskable || ret_nonmaskable)
		begin
			// both returns pop alike; only the non-maskable one ends nmi service
			state_d = IAS_RETURN;
			step_d = 3'h0;
			if (ret_nonmaskable)
				nmi_d = 1'b0; // RL19
			mem_rd_d = 1'b1;
			mem_addr_d = sp_q + 16'h0001; // RL20
		end
	end

	assign cpu_hold = (state_q != IAS_IDLE);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= IAS_IDLE;
			step_q <= 3'h0;
			slot_q <= SLOT_TRAP;
			sp_q <= SP_RESET;
			sp_base_q <= SP_RESET;
			pc_keep_q <= '0;
			psw_keep_q <= '0;
			byte_keep_q <= '0;
			master_irq_enable_q <= 1'b0;
			bank_select_q <= 1'b0;
			nmi_active_q <= 1'b0;
			trap_pend_q <= 1'b0;
			undef_pend_q <= 1'b0;
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_addr_q <= '0;
			mem_wdata_q <= '0;
			pc_load_q <= 1'b0;
			pc_new_q <= '0;
			flags_restore_q <= '0;
			flags_restore_load_q <= 1'b0;
			acc_clr_q <= '0;
			opcode_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			step_q <= step_d;
			slot_q <= slot_d;
			sp_q <= sp_d;
			sp_base_q <= sp_base_d;
			pc_keep_q <= pc_keep_d;
			psw_keep_q <= psw_keep_d;
			byte_keep_q <= byte_keep_d;
			master_irq_enable_q <= imf_d;
			bank_select_q <= bank_d;
			nmi_active_q <= nmi_d;
			trap_pend_q <= trap_pend_d;
			undef_pend_q <= undef_pend_d;
			mem_rd_q <= mem_rd_d;
			mem_wr_q <= mem_wr_d;
			mem_addr_q <= mem_addr_d;
			mem_wdata_q <= mem_wdata_d;
			pc_load_q <= pc_load_d;
			pc_new_q <= pc_new_d;
			flags_restore_q <= flags_d;
			flags_restore_load_q <= flags_load_d;
			acc_clr_q <= acc_clr_d;
			opcode_q <= opcode_d;
		end
	end
endmodule // ias_sequencer

/* File: tb/ias_mem_model.sv */
`timescale 1ns/100ps
// byte memory behind the sequencer: stack area and vector table
module ias_mem_model import ias_pkg::*; (
	input wire logic clk, // machine clock
	input wire logic mem_rd_q, // read strobe
	input wire logic mem_wr_q, // write strobe
	input wire logic [ADDR_W-1:0] mem_addr_q, // address
	input wire logic [DATA_W-1:0] mem_wdata_q, // write data
	output logic [DATA_W-1:0] mem_rdata // read data, one cycle late
);
	logic [DATA_W-1:0] mem [0:65535];
	// slot s holds entry {0x80 | s, 0x10}, high byte at the lower address
	initial
	begin
		for (int s = 0; s < 24; s++)
		begin
			mem[VEC_TABLE_TOP - 16'(2 * s)] = 8'h80 | 8'(s);
			mem[VEC_TABLE_TOP - 16'(2 * s) + 16'h1] = 8'h10;
		end
		mem_rdata = 8'h00;
	end
	// data is valid only the cycle after a read; the bus toggles otherwise so a late sample shows
	always @(posedge clk)
	begin
		if (mem_wr_q)
			mem[mem_addr_q] <= mem_wdata_q;
		if (mem_rd_q)
			mem_rdata <= mem[mem_addr_q];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule // ias_mem_model

/* File: tb/ias_sequencer_chk.sv */
`timescale 1ns/100ps
// port-level checks on stacking, vectoring, latches and busy time
module ias_sequencer_chk import ias_pkg::*; #(
	parameter int N_SRC = MASKABLE_COUNT,
	parameter logic [ADDR_W-1:0] VEC_TOP = VEC_TABLE_TOP
) (
	input wire logic clk, // machine clock
	input wire logic rst_b, // async reset, active low
	input wire logic [N_SRC-1:0] irq_request_latch, // held requests
	input wire logic [N_SRC-1:0] src_latch_clr, // instruction clears
	input wire logic undef_opcode, // undefined opcode pulse
	input wire logic master_irq_enable_q, // master enable
	input wire logic [ADDR_W-1:0] sp_q, // stack pointer
	input wire logic mem_rd_q, // read strobe
	input wire logic mem_wr_q, // write strobe
	input wire logic [ADDR_W-1:0] mem_addr_q, // memory address
	input wire logic [DATA_W-1:0] mem_rdata, // read data
	input wire logic pc_load_q, // pc load pulse
	input wire logic [ADDR_W-1:0] pc_new_q, // new pc
	input wire logic cpu_hold // sequence running
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// first push of a frame: a write with none just before it
	sequence s_first;
		mem_wr_q && !$past(mem_wr_q);
	endsequence
	a_imf_first: assert property (s_first |-> !master_irq_enable_q)
		else $error("master enable still set at first push");
	a_push_order: assert property (s_first |=> mem_wr_q && mem_addr_q == $past(mem_addr_q) - 16'h1
		##1 mem_wr_q && mem_addr_q == $past(mem_addr_q, 2) - 16'h2)
		else $error("stack pushes out of order");
	a_sp_drop: assert property (s_first |-> ##2 sp_q == mem_addr_q - 16'h1)
		else $error("stack pointer not lowered by three");
	a_vector_pc: assert property (pc_load_q && $past(mem_wr_q, 4)
		|-> pc_new_q == {$past(mem_rdata, 2), $past(mem_rdata)})
		else $error("vector not loaded high byte first");
	a_return_pc: assert property (pc_load_q && !$past(mem_wr_q, 4)
		|-> pc_new_q == {$past(mem_rdata, 2), $past(mem_rdata, 3)})
		else $error("return address not popped low byte first");
	a_load_ends: assert property (pc_load_q && $past(mem_wr_q, 4) |-> cpu_hold ##1 !cpu_hold)
		else $error("execution not resumed after pc load");
	// the return load arrives in the first free cycle, with the status byte restored
	a_return_ends: assert property (pc_load_q && !$past(mem_wr_q, 4)
		|-> !cpu_hold && $past(cpu_hold))
		else $error("return load not at the end of the pop");
	// an abort by an undefined opcode lengthens the sequence, so it is excluded
	a_hold_eight: assert property ($rose(cpu_hold) && mem_wr_q && !undef_opcode
		##1 (!undef_opcode) [*6] |-> cpu_hold ##1 !cpu_hold)
		else $error("acceptance not eight cycles");
	a_latch_drop: assert property ((($past(irq_request_latch) & ~irq_request_latch
		& ~$past(src_latch_clr)) != '0) |-> $past(cpu_hold) && !$past(cpu_hold, 2)
		&& $countones($past(irq_request_latch) & ~irq_request_latch) == 1)
		else $error("request latch lost outside acceptance");
	a_imf_holdoff: assert property ($rose(cpu_hold) && mem_wr_q && !$past(master_irq_enable_q)
		|-> ##3 mem_rd_q && mem_addr_q >= VEC_TOP - 16'h2)
		else $error("maskable source taken while disabled");
	c_accept: cover property ($rose(cpu_hold) && mem_wr_q);
	c_return: cover property (pc_load_q && !$past(mem_wr_q, 4));
	c_abort: cover property (undef_opcode && cpu_hold);
endmodule // ias_sequencer_chk

bind ias_sequencer ias_sequencer_chk #(.N_SRC(N_SRC), .VEC_TOP(VEC_TOP)) u_chk (.clk, .rst_b,
	.irq_request_latch, .src_latch_clr, .undef_opcode, .master_irq_enable_q, .sp_q, .mem_rd_q,
	.mem_wr_q, .mem_addr_q, .mem_rdata, .pc_load_q, .pc_new_q, .cpu_hold);

/* File: tb/interrupt_acceptance_sequencer_test.sv */
`timescale 1ns/100ps
// self-checking bench for the acceptance and return sequencer
module interrupt_acceptance_sequencer_test;
	import ias_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [21:0] src_irq_set = '0, src_latch_clr = '0, source_enable_flags = '0, irq_request_latch;
	logic instr_done = 1'b0, fetch_req = 1'b0, fetch_addr_ok = 1'b1, undef_opcode = 1'b0;
	logic imf_set = 1'b0, imf_clr = 1'b0, bank_wr = 1'b0, bank_wdata = 1'b0, sp_wr = 1'b0;
	logic ret_maskable = 1'b0, ret_nonmaskable = 1'b0, gpr_wr = 1'b0, idx_wr = 1'b0, idx_sel = 1'b0;
	logic [7:0] fetch_mem_data = 8'h00, gpr_wdata = 8'h00, opcode_q, mem_wdata_q, mem_rdata, gpr_rdata;
	logic [15:0] sp_wdata = 16'h0000, pc_cur = 16'h0000, idx_wdata = 16'h0000;
	logic [15:0] sp_q, mem_addr_q, pc_new_q, idx_rdata;
	logic [5:0] cpu_flags = 6'h00, flags_restore_q;
	logic [2:0] gpr_sel = 3'h0;
	logic flags_restore_load_q, master_irq_enable_q, bank_select_q, mem_rd_q, mem_wr_q;
	logic pc_load_q, cpu_hold, nmi_active_q;
	int fails = 0;
	int tests_run = 0;
	int n;
	ias_sequencer DUT (.clk, .rst_b, .src_irq_set, .src_latch_clr, .source_enable_flags,
		.irq_request_latch, .instr_done, .fetch_req, .fetch_addr_ok, .fetch_mem_data, .opcode_q,
		.undef_opcode, .imf_set, .imf_clr, .bank_wr, .bank_wdata, .sp_wr, .sp_wdata, .ret_maskable,
		.ret_nonmaskable, .pc_cur, .cpu_flags, .flags_restore_q, .flags_restore_load_q,
		.master_irq_enable_q, .bank_select_q, .sp_q, .mem_rd_q, .mem_wr_q, .mem_addr_q, .mem_wdata_q,
		.mem_rdata, .pc_load_q, .pc_new_q, .cpu_hold, .nmi_active_q, .gpr_wr, .gpr_sel, .gpr_wdata,
		.gpr_rdata, .idx_wr, .idx_sel, .idx_wdata, .idx_rdata);
	ias_mem_model u_mem (.clk, .mem_rd_q, .mem_wr_q, .mem_addr_q, .mem_wdata_q, .mem_rdata);
	always #12.5 clk = ~clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// inputs always move 2 ns after the edge so the design samples them cleanly
	task automatic step(input int k = 1);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step();
		s = 1'b0;
	endtask
	// count busy cycles; a sequencer that never lets go ends the run
	task automatic run_out();
		n = 0;
		while (cpu_hold !== 1'b0)
		begin
			if (n > 40)
			begin
				fails++;
				end_sim();
			end
			step();
			n++;
		end
	endtask
	function automatic logic [15:0] vec(input int s);
		return {8'h80 | 8'(s), 8'h10};
	endfunction
	task automatic t_reset();
		check(sp_q, SP_RESET);
		check({master_irq_enable_q, bank_select_q, cpu_hold, nmi_active_q}, 16'h0000);
		check(irq_request_latch[15:0], 16'h0000);
	endtask
	task automatic t_maskable();
		sp_wdata = 16'h0200;
		sp_wr = 1'b1;
		imf_set = 1'b1;
		gpr_sel = 3'h2;
		gpr_wdata = 8'h11;
		gpr_wr = 1'b1;
		source_enable_flags = 22'h28;
		src_irq_set = 22'h28;
		step();
		{sp_wr, imf_set, gpr_wr} = 3'b000;
		src_irq_set = '0;
		pc_cur = 16'h1234;
		cpu_flags = 6'h15;
		pulse(instr_done);
		run_out();
		check(16'(n), 16'h0007);
		check(irq_request_latch[15:0], 16'h0020);
		check(master_irq_enable_q, 1'b0);
		check(sp_q, 16'h01fd);
		check(u_mem.mem[16'h0200], 8'h95);
		check({u_mem.mem[16'h01ff], u_mem.mem[16'h01fe]}, 16'h1234);
		check(pc_new_q, vec(5));
		check(gpr_rdata, 8'h11);
		// handler drops the serviced enable, then moves to the spare bank
		source_enable_flags = 22'h20;
		bank_wdata = 1'b1;
		pulse(bank_wr);
		gpr_wdata = 8'h22;
		idx_wdata = 16'hbeef;
		{gpr_wr, idx_wr} = 2'b11;
		step();
		{gpr_wr, idx_wr} = 2'b00;
		check(gpr_rdata, 8'h22);
		check(idx_rdata, 16'hbeef);
		pulse(instr_done);
		check(cpu_hold, 1'b0);
		pulse(ret_maskable);
		run_out();
		check(16'(n), 16'h0004);
		check({pc_load_q, flags_restore_load_q}, 16'h0003);
		check(pc_new_q, 16'h1234);
		check(sp_q, 16'h0200);
		check({master_irq_enable_q, bank_select_q}, 16'h0002);
		check(flags_restore_q, 6'h15);
		check(gpr_rdata, 8'h11);
		check(idx_rdata, 16'h0000);
		// pending source 5 is masked by its own enable, then taken once enabled
		source_enable_flags = '0;
		pulse(instr_done);
		check(cpu_hold, 1'b0);
		source_enable_flags = 22'h20;
		step();
		pulse(instr_done);
		run_out();
		check(pc_new_q, vec(7));
		check(irq_request_latch[15:0], 16'h0000);
	endtask
	task automatic t_trap();
		fetch_addr_ok = 1'b0;
		pc_cur = 16'h0456;
		pulse(fetch_req);
		fetch_addr_ok = 1'b1;
		check(opcode_q, TRAP_OPCODE);
		for (n = 0; n < 4 && cpu_hold !== 1'b1; n++)
			step();
		check(cpu_hold, 1'b1);
		run_out();
		check(16'(n), 16'h0007);
		check(pc_new_q, vec(SLOT_TRAP));
		check(nmi_active_q, 1'b1);
		check(sp_q, 16'h01fa);
		// a real trap opcode nested in service, then aborted by an undefined opcode
		fetch_mem_data = TRAP_OPCODE;
		pc_cur = 16'h4321;
		pulse(fetch_req);
		for (n = 0; n < 4 && cpu_hold !== 1'b1; n++)
			step();
		check(cpu_hold, 1'b1);
		step(3);
		pulse(undef_opcode);
		run_out();
		check(pc_new_q, vec(SLOT_UNDEF));
		check(sp_q, 16'h01f7);
		check({u_mem.mem[16'h01f9], u_mem.mem[16'h01f8]}, 16'h4321);
		pulse(ret_nonmaskable);
		run_out();
		check(pc_new_q, 16'h4321);
		check(nmi_active_q, 1'b0);
		check(sp_q, 16'h01fa);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		step(2);
		rst_b = 1'b1;
		t_reset();
		t_maskable();
		t_trap();
		end_sim();
	end
endmodule // interrupt_acceptance_sequencer_test
